//--- logic/fcsi_status_irq.v
// Status flags, result code and interrupt enables of an embedded flash controller.
// Assumes the command engine runs on REF_CLK_IN and gives one-cycle event pulses.
//
// Local design decision: the address-and-strobe port.
`timescale 1ns/1ps
`include "fcsi_regs.vh"

// Function
// - Result code 00 reports a command or write finished without error.
// - Result code 01 reports a sign, write or erase on protected location.
// - Erase readback not all ones reports result code 10.
// - Signature differing from stored top four bytes reports result code 10.
// - Result code 11 reports a command or write ended by abort.
// - Write-nearly-finished bit 3 sets on the engine's nearly-finished pulse, before completion; clears on status read.
// - Write-nearly-finished marks when keyhole registers may be reloaded.
// - Op-finished bit 2 sets on command completion, stays until status read.
// - With back-to-back commands op-finished sets after the first completes.
// - Keyhole-locked bit 1 sets once the engine starts a keyhole write.
// - While locked, keyhole address and data writes are ignored; commands accepted.
// - Engine-active bit 0 is high while a register-issued command executes.
// - Fail enable bit 2 raises interrupt on completion with error result.
// - Nearly-finished enable bit 1 enables its interrupt and reads as zero.
// - Finish enable bit 0 raises interrupt on every completion.
// - Result field bits 5:4 keep the first error; status read clears it.
module fcsi_status_irq
(
    // Clock and reset.
    input wire REF_CLK_IN,
    input wire NRST_IN,
    // Register port.
    input wire [31:0] ADDR_IN,
    input wire [31:0] WDATA_IN,
    input wire WR_IN,
    input wire RD_IN,
    output reg [31:0] RDATA_OUT,
    // Command engine events.
    input wire DONE_IN,
    input wire WR_START_IN,
    input wire WR_NEAR_IN,
    input wire PROT_ERR_IN,
    input wire ABORT_IN,
    input wire VERIFY_VALID_IN,
    input wire [63:0] VERIFY_DATA_IN,
    input wire SIGN_VALID_IN,
    input wire [31:0] SIGN_CALC_IN,
    input wire [31:0] SIGN_STORED_IN,
    // Command and keyhole contents to the engine.
    output reg [`FCSI_CMD_W-1:0] CMD_OUT,
    output reg CMD_STB_OUT,
    output reg [`FCSI_KA_HI:`FCSI_KA_LO] KH_ADDR_OUT,
    output reg [31:0] KH_DATA_LO_OUT,
    output reg [31:0] KH_DATA_HI_OUT,
    // Interrupt and status.
    output reg IRQ_OUT,
    output reg BUSY_OUT
);

    reg [1:0] result_code;
    reg [1:0] cur_err;
    reg write_nearly_finished;
    reg op_finished_flag;
    reg keyhole_locked;
    reg engine_active;
    reg [`FCSI_IE_W-1:0] flash_interrupt_enable;

    reg [1:0] next_result_code;
    reg [1:0] next_cur_err;
    reg [1:0] ev_err;
    reg next_near;
    reg next_done;
    reg next_lock;
    reg next_active;
    reg next_irq;
    reg [`FCSI_IE_W-1:0] next_ie;
    reg [31:0] next_rdata;

    // Register decodes; the status register has no writable bits, so writes to it are dropped.
    wire rd_status = RD_IN && (ADDR_IN == `FCSI_STATUS_ADDR);
    wire wr_ie = WR_IN && (ADDR_IN == `FCSI_IRQ_EN_ADDR);
    wire wr_cmd = WR_IN && (ADDR_IN == `FCSI_CMD_ADDR);
    wire wr_ka = WR_IN && (ADDR_IN == `FCSI_KH_ADDR_ADDR);
    wire wr_dlo = WR_IN && (ADDR_IN == `FCSI_KH_DLO_ADDR);
    wire wr_dhi = WR_IN && (ADDR_IN == `FCSI_KH_DHI_ADDR);
    wire verify_bad = VERIFY_VALID_IN && (VERIFY_DATA_IN != `FCSI_ONES64);
    wire sign_bad = SIGN_VALID_IN && (SIGN_CALC_IN != SIGN_STORED_IN);

    // Error seen in this cycle, in fixed priority when several coincide.
    always @*
    begin
        if (ABORT_IN)
        begin
            ev_err = `FCSI_RES_ABORT;
        end
        else if (PROT_ERR_IN)
        begin
            ev_err = `FCSI_RES_PROT;
        end
        else if (verify_bad)
        begin
            ev_err = `FCSI_RES_VERIFY;
        end
        else if (sign_bad)
        begin
            ev_err = `FCSI_RES_VERIFY;
        end
        else
        begin
            ev_err = `FCSI_RES_OK;
        end
    end

    // Error of the command in flight, held until its completion hands it on.
    always @*
    begin
        next_cur_err = cur_err;
        if (cur_err == `FCSI_RES_OK)
        begin
            next_cur_err = ev_err;
        end
        if (DONE_IN)
        begin
            next_cur_err = `FCSI_RES_OK;
        end
    end

    // Result field keeps the first error; a completion in the reading cycle still lands.
    always @*
    begin
        next_result_code = result_code;
        if (rd_status)
        begin
            next_result_code = `FCSI_RES_OK;
        end
        if (DONE_IN && (result_code == `FCSI_RES_OK || rd_status))
        begin
            if (cur_err != `FCSI_RES_OK)
            begin
                next_result_code = cur_err;
            end
            else
            begin
                next_result_code = ev_err;
            end
        end
    end

    // Status flags: a hardware event wins over the clear of a status read in the same cycle.
    always @*
    begin
        next_done = op_finished_flag;
        if (rd_status)
        begin
            next_done = 1'b0;
        end
        if (DONE_IN)
        begin
            next_done = 1'b1;
        end
    end

    always @*
    begin
        next_near = write_nearly_finished;
        if (rd_status)
        begin
            next_near = 1'b0;
        end
        if (WR_NEAR_IN)
        begin
            next_near = 1'b1;
        end
    end

    // The keyhole reopens as soon as the write is nearly finished, not only at completion.
    always @*
    begin
        next_lock = keyhole_locked;
        if (WR_NEAR_IN || DONE_IN)
        begin
            next_lock = 1'b0;
        end
        if (WR_START_IN)
        begin
            next_lock = 1'b1;
        end
    end

    // A command written in the completing cycle keeps the engine busy.
    always @*
    begin
        next_active = engine_active;
        if (DONE_IN)
        begin
            next_active = 1'b0;
        end
        if (wr_cmd)
        begin
            next_active = 1'b1;
        end
    end

    always @*
    begin
        next_ie = flash_interrupt_enable;
        if (wr_ie)
        begin
            next_ie = WDATA_IN[`FCSI_IE_W-1:0];
        end
    end

    // Interrupt level follows the next flag values so it rises with the flag it reports.
    always @*
    begin
        next_irq = (next_ie[`FCSI_IE_FINISH] && next_done)
            || (next_ie[`FCSI_IE_NEAR] && next_near)
            || (next_ie[`FCSI_IE_FAIL] && next_done
                && (next_result_code != `FCSI_RES_OK));
    end

    // Read data, presented in the cycle after the read strobe.
    always @*
    begin
        next_rdata = `FCSI_ZERO32;
        if (RD_IN)
        begin
            case (ADDR_IN)
                `FCSI_STATUS_ADDR:
                begin
                    next_rdata[`FCSI_ST_BUSY] = engine_active;
                    next_rdata[`FCSI_ST_LOCK] = keyhole_locked;
                    next_rdata[`FCSI_ST_DONE] = op_finished_flag;
                    next_rdata[`FCSI_ST_NEAR] = write_nearly_finished;
                    next_rdata[`FCSI_ST_RES_HI:`FCSI_ST_RES_LO] = result_code;
                end
                `FCSI_IRQ_EN_ADDR:
                begin
                    next_rdata[`FCSI_IE_FINISH] = flash_interrupt_enable[`FCSI_IE_FINISH];
                    next_rdata[`FCSI_IE_FAIL] = flash_interrupt_enable[`FCSI_IE_FAIL];
                    next_rdata[`FCSI_IE_NEAR] = 1'b0;
                end
                `FCSI_CMD_ADDR:
                    next_rdata[`FCSI_CMD_W-1:0] = CMD_OUT;
                `FCSI_KH_ADDR_ADDR:
                    next_rdata[`FCSI_KA_HI:`FCSI_KA_LO] = KH_ADDR_OUT;
                `FCSI_KH_DLO_ADDR:
                    next_rdata = KH_DATA_LO_OUT;
                `FCSI_KH_DHI_ADDR:
                    next_rdata = KH_DATA_HI_OUT;
                default:
                    next_rdata = `FCSI_ZERO32;
            endcase
        end
    end

    always @(posedge REF_CLK_IN or negedge NRST_IN)
    begin
        if (!NRST_IN)
        begin
            result_code <= `FCSI_RES_OK;
            cur_err <= `FCSI_RES_OK;
            write_nearly_finished <= 1'b0;
            op_finished_flag <= 1'b0;
            keyhole_locked <= 1'b0;
            engine_active <= 1'b0;
            flash_interrupt_enable <= {`FCSI_IE_W{1'b0}};
            RDATA_OUT <= `FCSI_ZERO32;
            IRQ_OUT <= 1'b0;
            BUSY_OUT <= 1'b0;
        end
        else
        begin
            result_code <= next_result_code;
            cur_err <= next_cur_err;
            write_nearly_finished <= next_near;
            op_finished_flag <= next_done;
            keyhole_locked <= next_lock;
            engine_active <= next_active;
            flash_interrupt_enable <= next_ie;
            RDATA_OUT <= next_rdata;
            IRQ_OUT <= next_irq;
            BUSY_OUT <= next_active;
        end
    end

    // Command and keyhole registers; keyhole writes are dropped while locked.
    always @(posedge REF_CLK_IN or negedge NRST_IN)
    begin
        if (!NRST_IN)
        begin
            CMD_OUT <= {`FCSI_CMD_W{1'b0}};
            CMD_STB_OUT <= 1'b0;
            KH_ADDR_OUT <= {(`FCSI_KA_HI - `FCSI_KA_LO + 1){1'b0}};
            KH_DATA_LO_OUT <= `FCSI_ZERO32;
            KH_DATA_HI_OUT <= `FCSI_ZERO32;
        end
        else
        begin
            CMD_STB_OUT <= wr_cmd;
            if (wr_cmd)
                CMD_OUT <= WDATA_IN[`FCSI_CMD_W-1:0];
            if (wr_ka && !keyhole_locked)
                KH_ADDR_OUT <= WDATA_IN[`FCSI_KA_HI:`FCSI_KA_LO];
            if (wr_dlo && !keyhole_locked)
                KH_DATA_LO_OUT <= WDATA_IN;
            if (wr_dhi && !keyhole_locked)
                KH_DATA_HI_OUT <= WDATA_IN;
        end
    end

endmodule // fcsi_status_irq

//--- logic/fcsi_regs.vh
// Register map, field positions and result codes of the flash status and interrupt block.
// Included by the design file; holds definitions only.
`ifndef FCSI_REGS_VH
`define FCSI_REGS_VH

// Byte addresses of the registers.
`define FCSI_STATUS_ADDR 32'h40018000
`define FCSI_IRQ_EN_ADDR 32'h40018004
`define FCSI_CMD_ADDR 32'h40018008
`define FCSI_KH_ADDR_ADDR 32'h4001800C
`define FCSI_KH_DLO_ADDR 32'h40018010
`define FCSI_KH_DHI_ADDR 32'h40018014

// Status register fields.
`define FCSI_ST_BUSY 0
`define FCSI_ST_LOCK 1
`define FCSI_ST_DONE 2
`define FCSI_ST_NEAR 3
`define FCSI_ST_RES_LO 4
`define FCSI_ST_RES_HI 5

// Interrupt enable fields.
`define FCSI_IE_FINISH 0
`define FCSI_IE_NEAR 1
`define FCSI_IE_FAIL 2
`define FCSI_IE_W 3

// Command and keyhole address fields.
`define FCSI_CMD_W 5
`define FCSI_KA_HI 18
`define FCSI_KA_LO 3

// Result codes.
`define FCSI_RES_OK 2'h0
`define FCSI_RES_PROT 2'h1
`define FCSI_RES_VERIFY 2'h2
`define FCSI_RES_ABORT 2'h3

// Reset value and erase-check all-ones pattern.
`define FCSI_ZERO32 32'h00000000
`define FCSI_ONES64 64'hFFFFFFFFFFFFFFFF

`endif

//--- verification/fcsi_status_irq_checker.sv
// Concurrent checks on the flash status and interrupt block.
// Bound to fcsi_status_irq and sees only its ports.
`timescale 1ns/1ps
`include "fcsi_regs.vh"
module fcsi_checker
(
    // Clock, reset and register port.
    input wire REF_CLK_IN,
    input wire NRST_IN,
    input wire [31:0] ADDR_IN,
    input wire [31:0] WDATA_IN,
    input wire WR_IN,
    input wire RD_IN,
    // Engine events.
    input wire DONE_IN,
    input wire WR_START_IN,
    input wire WR_NEAR_IN,
    // Watched outputs.
    input wire [31:0] RDATA_OUT,
    input wire [4:0] CMD_OUT,
    input wire CMD_STB_OUT,
    input wire [31:0] KH_DATA_LO_OUT,
    input wire IRQ_OUT,
    input wire BUSY_OUT
);
    default clocking cb @(posedge REF_CLK_IN); endclocking
    default disable iff (!NRST_IN);
    wire rd_st = RD_IN && ADDR_IN == `FCSI_STATUS_ADDR;
    wire evt = DONE_IN || WR_NEAR_IN;
    wire [4:0] wd5 = WDATA_IN[4:0];
    reg ie0;
    reg lk;
    // Shadow of the keyhole lock: set when a write starts, reopened by near-finish or completion.
    always @(posedge REF_CLK_IN or negedge NRST_IN)
        if (!NRST_IN)
            lk <= 1'b0;
        else if (WR_START_IN)
            lk <= 1'b1;
        else if (evt)
            lk <= 1'b0;
    // Shadow of the finish enable, so the interrupt can be tied to its cause.
    always @(posedge REF_CLK_IN or negedge NRST_IN)
        if (!NRST_IN)
            ie0 <= 1'b0;
        else if (WR_IN && ADDR_IN == `FCSI_IRQ_EN_ADDR)
            ie0 <= WDATA_IN[0];
    property p_cmd; WR_IN && ADDR_IN == `FCSI_CMD_ADDR |=> CMD_STB_OUT && BUSY_OUT && CMD_OUT == $past(wd5); endproperty
    a_cmd: assert property (p_cmd) else $error("command write not taken");
    property p_idle; DONE_IN && !WR_IN |=> !BUSY_OUT; endproperty
    a_idle: assert property (p_idle) else $error("busy after completion");
    property p_done; DONE_IN ##1 rd_st |=> RDATA_OUT[2]; endproperty
    a_done: assert property (p_done) else $error("done flag missing");
    property p_near; WR_NEAR_IN && !WR_START_IN ##1 rd_st |=> RDATA_OUT[3] && !RDATA_OUT[1]; endproperty
    a_near: assert property (p_near) else $error("nearly finished flag wrong");
    property p_clr; rd_st && !evt ##1 !evt ##1 rd_st |=> RDATA_OUT[5:2] == 4'h0; endproperty
    a_clr: assert property (p_clr) else $error("status read did not clear");
    property p_ie; RD_IN && ADDR_IN == `FCSI_IRQ_EN_ADDR |=> RDATA_OUT[31:3] == 29'h0 && !RDATA_OUT[1]; endproperty
    a_ie: assert property (p_ie) else $error("enable readback wrong");
    property p_lock; lk && WR_IN && ADDR_IN == `FCSI_KH_DLO_ADDR |=> $stable(KH_DATA_LO_OUT); endproperty
    a_lock: assert property (p_lock) else $error("locked keyhole written");
    property p_fin; ie0 && DONE_IN && !(WR_IN && ADDR_IN == `FCSI_IRQ_EN_ADDR) |=> IRQ_OUT; endproperty
    a_fin: assert property (p_fin) else $error("finish interrupt missing");
    property p_hold; (!RD_IN && !WR_IN) [*2] ##0 IRQ_OUT |=> IRQ_OUT; endproperty
    a_hold: assert property (p_hold) else $error("interrupt dropped while pending");
endmodule // fcsi_checker

bind fcsi_status_irq fcsi_checker u_chk (.REF_CLK_IN(REF_CLK_IN), .NRST_IN(NRST_IN), .ADDR_IN(ADDR_IN),
    .WDATA_IN(WDATA_IN), .WR_IN(WR_IN), .RD_IN(RD_IN), .DONE_IN(DONE_IN), .WR_START_IN(WR_START_IN),
    .WR_NEAR_IN(WR_NEAR_IN), .RDATA_OUT(RDATA_OUT), .CMD_OUT(CMD_OUT), .CMD_STB_OUT(CMD_STB_OUT),
    .KH_DATA_LO_OUT(KH_DATA_LO_OUT), .IRQ_OUT(IRQ_OUT), .BUSY_OUT(BUSY_OUT));

//--- verification/fcsi_status_irq_tb.sv
// Self-checking bench for the flash status and interrupt block.
// Drives the register port and the engine event pulses directly.
`timescale 1ns/1ps
`include "fcsi_regs.vh"
module fcsi_status_irq_tb;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [31:0] addr = 32'h0, wdata = 32'h0, rdata, d, khl, khh;
    logic [6:0] ev = 7'h00;
    logic [63:0] vdata = 64'h0;
    logic [31:0] scalc = 32'h0;
    logic [4:0] cmd;
    logic [18:3] kha;
    logic stb, irq, busy;
    int error_cnt = 0, num_checks = 0, cyc = 0;
    logic [6:0] em [5] = '{7'h08, 7'h20, 7'h40, 7'h10, 7'h20};
    logic [1:0] ec [5] = '{2'h1, 2'h2, 2'h2, 2'h3, 2'h0};
    fcsi_status_irq dut (.REF_CLK_IN(clk), .NRST_IN(nrst), .ADDR_IN(addr), .WDATA_IN(wdata), .WR_IN(wr), .RD_IN(rd),
        .RDATA_OUT(rdata), .DONE_IN(ev[0]), .WR_START_IN(ev[1]), .WR_NEAR_IN(ev[2]), .PROT_ERR_IN(ev[3]),
        .ABORT_IN(ev[4]), .VERIFY_VALID_IN(ev[5]), .VERIFY_DATA_IN(vdata), .SIGN_VALID_IN(ev[6]),
        .SIGN_CALC_IN(scalc), .SIGN_STORED_IN(32'h12345678), .CMD_OUT(cmd), .CMD_STB_OUT(stb), .KH_ADDR_OUT(kha),
        .KH_DATA_LO_OUT(khl), .KH_DATA_HI_OUT(khh), .IRQ_OUT(irq), .BUSY_OUT(busy));
    initial
    begin
        forever #20 clk = ~clk;
    end
    task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", n, exp, seen);
        end
    endtask
    task automatic wr_reg(input logic [31:0] a, input logic [31:0] v);
        @(posedge clk);
        {wr, addr, wdata} <= {1'b1, a, v};
        @(posedge clk);
        wr <= 1'b0;
        #1;
    endtask
    task automatic rd_reg(input logic [31:0] a, output logic [31:0] v);
        @(posedge clk);
        {rd, addr} <= {1'b1, a};
        @(posedge clk);
        rd <= 1'b0;
        #1 v = rdata;
    endtask
    task automatic pulse(input logic [6:0] m);
        @(posedge clk);
        ev <= m;
        @(posedge clk);
        ev <= 7'h00;
        #1;
    endtask
    task automatic t_regs();
        rd_reg(`FCSI_IRQ_EN_ADDR, d); chk("ie_reset", d, 32'h0);
        wr_reg(`FCSI_IRQ_EN_ADDR, 32'hFFFFFFFF); rd_reg(`FCSI_IRQ_EN_ADDR, d); chk("ie_rw", d, 32'h5);
        @(posedge clk); #1 chk("rdata_idle", rdata, 32'h0);
        rd_reg(32'h40018040, d); chk("unmapped", d, 32'h0);
        rd_reg(`FCSI_STATUS_ADDR, d); chk("status_reset", d, 32'h0);
        $display("test regs done");
    endtask
    task automatic t_cmd();
        wr_reg(`FCSI_IRQ_EN_ADDR, 32'h1);
        wr_reg(`FCSI_CMD_ADDR, 32'h5); chk("busy", {stb, busy, cmd}, 32'h65);
        pulse(7'h01); chk("busy_end", busy, 1'b0);
        chk("irq_finish", irq, 1'b1);
        wr_reg(`FCSI_CMD_ADDR, 32'h3);
        rd_reg(`FCSI_STATUS_ADDR, d); chk("done_first", d, 32'h5);
        pulse(7'h01); rd_reg(`FCSI_STATUS_ADDR, d); chk("done_ok", d, 32'h4);
        @(posedge clk); #1 chk("irq_drop", irq, 1'b0);
        $display("test cmd done");
    endtask
    task automatic t_err();
        wr_reg(`FCSI_IRQ_EN_ADDR, 32'h4);
        for (int i = 0; i < 5; i++)
        begin
            vdata <= (i == 4) ? 64'hFFFFFFFFFFFFFFFF : 64'hFFFFFFFFFFFFFFFE;
            scalc <= 32'h12345679;
            wr_reg(`FCSI_CMD_ADDR, 32'h1); pulse(em[i]); pulse(7'h01);
            chk("irq_fail", irq, ec[i] != 2'h0);
            rd_reg(`FCSI_STATUS_ADDR, d); chk("result", d, {ec[i], 4'h4});
        end
        wr_reg(`FCSI_CMD_ADDR, 32'h1); pulse(7'h08); pulse(7'h01);
        wr_reg(`FCSI_CMD_ADDR, 32'h1); pulse(7'h10); pulse(7'h01);
        rd_reg(`FCSI_STATUS_ADDR, d); chk("first_err", d, 32'h14);
        rd_reg(`FCSI_STATUS_ADDR, d); chk("err_clr", d, 32'h0);
        $display("test err done");
    endtask
    task automatic t_kh();
        wr_reg(`FCSI_KH_ADDR_ADDR, 32'h0007FFF8); wr_reg(`FCSI_KH_DLO_ADDR, 32'hA5A5A5A5);
        wr_reg(`FCSI_KH_DHI_ADDR, 32'h5A5A5A5A);
        rd_reg(`FCSI_KH_ADDR_ADDR, d); chk("kh_addr_rd", d, 32'h0007FFF8);
        wr_reg(`FCSI_CMD_ADDR, 32'h2); pulse(7'h02);
        rd_reg(`FCSI_STATUS_ADDR, d); chk("locked", d, 32'h3);
        wr_reg(`FCSI_KH_DLO_ADDR, 32'h0); chk("kh_data", khl, 32'hA5A5A5A5);
        wr_reg(`FCSI_KH_DHI_ADDR, 32'h0); chk("kh_data_hi", khh, 32'h5A5A5A5A);
        wr_reg(`FCSI_KH_ADDR_ADDR, 32'h0); chk("kh_addr", kha, 16'hFFFF);
        wr_reg(`FCSI_CMD_ADDR, 32'h4); chk("cmd_open", cmd, 5'h04);
        rd_reg(`FCSI_CMD_ADDR, d); chk("cmd_rd", d, 32'h4);
        pulse(7'h04); rd_reg(`FCSI_STATUS_ADDR, d); chk("near", d, 32'h9);
        wr_reg(`FCSI_KH_DLO_ADDR, 32'h1); chk("kh_reopen", khl, 32'h1);
        pulse(7'h01); rd_reg(`FCSI_STATUS_ADDR, d); chk("near_clr", d, 32'h4);
        $display("test keyhole done");
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            error_cnt++;
            print_verdict();
        end
    end
    initial
    begin
        repeat (8) @(posedge clk);
        nrst <= 1'b1;
        t_regs();
        t_cmd();
        t_err();
        t_kh();
        print_verdict();
    end
endmodule // fcsi_status_irq_tb
